// file: rtl/eeprom_master_regs.svh
// Constants for the serial EEPROM master engine
`ifndef EEPROM_MASTER_REGS_SVH
`define EEPROM_MASTER_REGS_SVH
`define CLK_FREQ_HZ        100000000
`define I2C_RATE_HZ        100000
`define I2C_QTR_CYCLES     ((`CLK_FREQ_HZ / `I2C_RATE_HZ) / 4)
`define TIMEOUT_MS         30
`define TIMEOUT_CYCLES     ((`CLK_FREQ_HZ / 1000) * `TIMEOUT_MS)
`define CTRL_CODE          4'ha
`define MW_OP_ERASE        2'h3
`define MW_OP_READ         2'h2
`define MW_OP_WRITE        2'h1
`define MW_OP_EXT          2'h0
`define MW_EXT_ERASE_ALL_CMD        2'h2
`define MW_EXT_WRITE_DISABLE_CMD        2'h0
`define MW_EXT_WRITE_ENABLE_CMD        2'h3
`define MW_EXT_WRITE_ALL_CMD        2'h1
`define MW_ABITS_7         5'h07
`define MW_ABITS_9         5'h09
`define MW_ABITS_11        5'h0b
`endif

// file: rtl/eeprom_master_pkg.sv
// Types shared by the serial EEPROM master engine
package eeprom_master_pkg;
  typedef enum logic [2:0] {
    CMD_READ   = 3'h0,
    CMD_WRITE  = 3'h1,
    CMD_ERASE  = 3'h2,
    CMD_ERASE_ALL_CMD   = 3'h3,
    CMD_WRITE_DISABLE_CMD   = 3'h4,
    CMD_WRITE_ENABLE_CMD   = 3'h5,
    CMD_WRITE_ALL_CMD   = 3'h6
  } eeprom_cmd_e;
endpackage : eeprom_master_pkg

// file: rtl/eeprom_master.sv
// Serial EEPROM master engine: two-wire byte/sequential read, byte write, three-wire command set
//
// How it works
// - Reads send start, control 1010+select+read bit, take ack and eight data bits.
// - Last byte of a single read gets no-ack, then a stop.
// - A missing ack from the EEPROM outside polling aborts the sequence and sets the timeout flag.
// - Sequential read acks every byte but the last, which gets no-ack and stop.
// - Sequential read is offered to the loader through a byte count and strobe.
// - Byte write sends data after address acks, checks its ack, ends with stop.
// - After a write, poll with start and control byte 1010 000 0 while no-ack.
// - Polling longer than 30 ms ends with a timeout report.
// - Acked poll finishes with start immediately followed by stop.
// - Size strap selects 7, 9 or 11 address bits; code 11 reserved, but here code 11 also selects 11 address bits.
// - Every address bit of the chosen width is driven as held in the address field, except the two top bits for opcode 00.
// - Three-wire command: start bit 1, two-bit opcode, full address.
// - Opcode 00 commands are told apart by the two top address bits.
// - Commands take 10/12/14 clocks, data commands 18/20/22.
// - Writes send eight bits msb first after the address, all of wr_data only with 11 address bits; reads take eight bits back.
// - Single-byte parts carry address bits 10..8 in the select bits, else zero.
// - Busy bit set starts an operation; cleared at completion with read data ready.
// - Two-wire clock runs at 100 kHz.
`timescale 1ns/10ps
`include "eeprom_master_regs.svh"
module eeprom_master
  import eeprom_master_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        type_strap,        // 1: three-wire part, 0: two-wire part
  input  wire logic [1:0]  size_strap,
  input  wire logic        busy_set,          // Software sets eeprom_busy_bit
  input  wire logic [2:0]  cmd,
  input  wire logic [10:0] eeprom_address_field,
  input  wire logic [7:0]  wr_data,
  input  wire logic [7:0]  seq_count,         // Extra bytes for loader sequential read
  input  wire logic        seq_next,          // Loader took the current byte
  output logic             eeprom_busy_bit,
  output logic             eeprom_timeout_flag,
  output logic [7:0]       eeprom_data_register,
  output logic             seq_valid,
  output logic             ready_busy_status,
  input  wire logic        scl_in,
  output logic             scl_oe,            // Open drain: high pulls low
  input  wire logic        sda_in,
  output logic             sda_oe,
  output logic             mw_cs,
  output logic             mw_sk,
  output logic             mw_di,
  input  wire logic        mw_do
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] sda_s_reg, scl_s_reg, do_s_reg;
  always_ff @(posedge clk) begin
    sda_s_reg <= {sda_s_reg[0], sda_in};
    scl_s_reg <= {scl_s_reg[0], scl_in};
    do_s_reg  <= {do_s_reg[0], mw_do};
  end
  wire sda_q = sda_s_reg[1];
  wire scl_q = scl_s_reg[1];
  wire mdo_q = do_s_reg[1];

  // ==========================================================
  // Quarter-bit tick and timeout counter
  logic [7:0]  qtr_reg;
  logic [21:0] tmo_reg;
  wire stretch = scl_oe == 1'b0 && scl_q == 1'b0 && !type_strap; // Slave holds clock
  wire tick    = (qtr_reg == 8'(`I2C_QTR_CYCLES - 1)) && !stretch;
  wire tmo_hit = tmo_reg == 22'(`TIMEOUT_CYCLES - 1);

  // ==========================================================
  // Sequencer: a bit is four quarter phases, shift register drives bits
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001, S_START = 7'b0000010, S_BIT = 7'b0000100,
    S_STOP = 7'b0001000, S_BUSYW = 7'b0010000, S_CSLOW = 7'b0100000,
    S_DONE = 7'b1000000
  } state_e;
  typedef enum logic [3:0] {
    P_CTRLW = 4'b0001, P_ADDR = 4'b0010, P_DATA = 4'b0100, P_POLL = 4'b1000
  } phase_e;
  state_e      st_reg;
  logic [1:0]  q_reg;           // Quarter within a bit
  logic [4:0]  bit_reg;         // Bits left in current group
  logic [22:0] sh_reg;          // Outgoing bits, msb first
  logic [7:0]  rx_reg;
  logic        rd_phase_reg;    // Receiving data bytes
  logic        ack_slot_reg;    // Current bit is the ninth (ack) bit
  logic [1:0]  stage_reg;       // Two-wire stage: 0 ctrl/addr, 1 rd ctrl, 2 data, 3 poll
  logic [7:0]  left_reg;
  logic        ackd_reg;
  logic        fin_start_reg;   // Acked poll: start then stop

  // ==========================================================
  // Command decode
  wire [1:0] mw_op = (cmd == CMD_READ) ? `MW_OP_READ : (cmd == CMD_WRITE) ? `MW_OP_WRITE :
                     (cmd == CMD_ERASE) ? `MW_OP_ERASE : `MW_OP_EXT;
  wire [1:0] mw_ext = (cmd == CMD_ERASE_ALL_CMD) ? `MW_EXT_ERASE_ALL_CMD : (cmd == CMD_WRITE_DISABLE_CMD) ? `MW_EXT_WRITE_DISABLE_CMD :
                      (cmd == CMD_WRITE_ENABLE_CMD) ? `MW_EXT_WRITE_ENABLE_CMD : `MW_EXT_WRITE_ALL_CMD;
  wire [4:0] abits = (size_strap == 2'h0) ? `MW_ABITS_7 :
                     (size_strap == 2'h1) ? `MW_ABITS_9 : `MW_ABITS_11;
  // Extended commands put their sub-code in the two top bits of the chosen width
  wire [10:0] al_field = eeprom_address_field << (5'd11 - abits);
  wire [10:0] mw_al    = (mw_op == `MW_OP_EXT) ? {mw_ext, al_field[8:0]} : al_field;
  wire        mw_dat = (cmd == CMD_WRITE) || (cmd == CMD_WRITE_ALL_CMD);
  wire        mw_rd  = cmd == CMD_READ;
  // Bits shifted out: start+op+addr, plus eight data or eight read slots
  wire [4:0]  mw_len = 5'd3 + abits + ((mw_dat || mw_rd) ? 5'd8 : 5'd0);
  wire        two_byte = size_strap[0];
  wire [2:0]  sel = two_byte ? 3'h0 : eeprom_address_field[10:8];
  wire [7:0]  ctrl_w = {`CTRL_CODE, sel, 1'b0};
  wire [7:0]  ctrl_r = {`CTRL_CODE, sel, 1'b1};
  wire [7:0]  ctrl_p = {`CTRL_CODE, 3'h0, 1'b0};
  wire        i2c_rd = cmd == CMD_READ;
  wire        last_rx = left_reg == 8'h00;
  wire        bit_end = tick && q_reg == 2'h3;
  wire        ack_bad = ack_slot_reg && !rd_phase_reg && sda_q;   // Sampled at high phase

  // ==========================================================
  // Main sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= S_IDLE; q_reg <= 2'h0; bit_reg <= 5'h0; sh_reg <= 23'h0;
      rx_reg <= 8'h0; rd_phase_reg <= 1'b0; ack_slot_reg <= 1'b0; stage_reg <= 2'h0;
      left_reg <= 8'h0; ackd_reg <= 1'b0; fin_start_reg <= 1'b0; qtr_reg <= 8'h0;
      tmo_reg <= 22'h0; eeprom_busy_bit <= 1'b0; eeprom_timeout_flag <= 1'b0;
      eeprom_data_register <= 8'h0; seq_valid <= 1'b0; ready_busy_status <= 1'b0;
      scl_oe <= 1'b0; sda_oe <= 1'b0; mw_cs <= 1'b0; mw_sk <= 1'b0; mw_di <= 1'b0;
    end else begin
      qtr_reg <= (tick || st_reg == S_IDLE) ? 8'h0 : (stretch ? qtr_reg : qtr_reg + 8'h1);
      if (seq_next) seq_valid <= 1'b0;
      unique case (st_reg)
        S_IDLE: begin
          mw_cs <= 1'b0; mw_sk <= 1'b0;
          if (busy_set) begin
            eeprom_busy_bit <= 1'b1; eeprom_timeout_flag <= 1'b0; tmo_reg <= 22'h0;
            q_reg <= 2'h0; rd_phase_reg <= 1'b0; ack_slot_reg <= 1'b0; left_reg <= seq_count;
            if (type_strap) begin
              st_reg  <= S_BIT;  mw_cs <= 1'b1;
              bit_reg <= mw_len;
              sh_reg  <= {1'b1, mw_op, mw_al, (mw_dat ? wr_data : 8'h0), 1'b0};
            end else begin
              st_reg <= S_START; stage_reg <= 2'h0;
              sh_reg <= {ctrl_w, 1'b1, eeprom_address_field[7:0], 1'b1, 5'h0};
              bit_reg <= 5'd9;
            end
          end
        end
        // SDA falls while SCL high; SCL released a quarter late so a repeated start keeps a full low phase
        S_START: if (tick) begin
          q_reg <= q_reg + 2'h1;
          unique case (q_reg)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            default: begin
              scl_oe <= 1'b1;
              if (fin_start_reg) st_reg <= S_STOP;
              else st_reg <= S_BIT;
            end
          endcase
        end
        S_BIT: begin
          if (type_strap && tick) begin             // Three-wire: sk high on q2
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0) mw_di <= sh_reg[22];
            if (q_reg == 2'h1) mw_sk <= 1'b1;
            if (q_reg == 2'h2) rx_reg <= {rx_reg[6:0], mdo_q};
            if (q_reg == 2'h3) begin
              mw_sk <= 1'b0; sh_reg <= {sh_reg[21:0], 1'b0}; bit_reg <= bit_reg - 5'h1;
              if (bit_reg == 5'h1) begin
                if (mw_rd) eeprom_data_register <= rx_reg;   // Last bit already taken at q2
                st_reg <= S_CSLOW;
              end
            end
          end else if (!type_strap && tick) begin
            q_reg <= q_reg + 2'h1;
            unique case (q_reg)
              2'h0: sda_oe <= rd_phase_reg ? (ack_slot_reg && !last_rx)
                                           : (!ack_slot_reg && !sh_reg[22]);
              2'h1: scl_oe <= 1'b0;
              2'h2: if (!ack_slot_reg) rx_reg <= {rx_reg[6:0], sda_q};
              default: begin
                scl_oe <= 1'b1; sh_reg <= {sh_reg[21:0], 1'b0}; bit_reg <= bit_reg - 5'h1;
                if (ack_slot_reg) begin
                  ack_slot_reg <= 1'b0; bit_reg <= 5'd9;
                  if (ack_bad && stage_reg == 2'h3) begin
                    st_reg <= S_STOP; ackd_reg <= 1'b0;
                  end else if (ack_bad) begin
                    eeprom_timeout_flag <= 1'b1; st_reg <= S_STOP; ackd_reg <= 1'b0;
                  end else if (stage_reg == 2'h3) begin
                    fin_start_reg <= 1'b1; st_reg <= S_START; q_reg <= 2'h0; ackd_reg <= 1'b1;
                  end else if (rd_phase_reg) begin
                    eeprom_data_register <= rx_reg; seq_valid <= 1'b1;
                    if (last_rx) st_reg <= S_STOP;
                    else left_reg <= left_reg - 8'h1;
                  end else if (sh_reg[21:14] == 8'h0 && !rd_phase_reg) begin
                    // Byte group done: control/address, read control or write data
                    if (i2c_rd && stage_reg == 2'h0) begin
                      stage_reg <= 2'h1; st_reg <= S_START; q_reg <= 2'h0;
                      sh_reg <= {ctrl_r, 1'b1, 14'h0};
                    end else if (stage_reg == 2'h1) begin
                      rd_phase_reg <= 1'b1; sh_reg <= 23'h7fffff;
                    end else if (stage_reg == 2'h0) begin
                      stage_reg <= 2'h2; sh_reg <= {wr_data, 1'b1, 14'h0};
                    end else begin
                      stage_reg <= 2'h3; st_reg <= S_STOP; ackd_reg <= 1'b0;
                    end
                  end
                end else if (bit_reg == 5'h2) ack_slot_reg <= 1'b1;
              end
            endcase
          end
        end
        S_STOP: if (tick) begin                      // SDA rises while SCL high
          q_reg <= q_reg + 2'h1;
          unique case (q_reg)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            default: begin
              if (eeprom_timeout_flag || (rd_phase_reg) || fin_start_reg) begin
                st_reg <= S_DONE; fin_start_reg <= 1'b0;
              end else begin                          // Start or repeat poll
                stage_reg <= 2'h3; st_reg <= S_START; bit_reg <= 5'd9;
                sh_reg <= {ctrl_p, 1'b1, 14'h0};
                if (ackd_reg) fin_start_reg <= 1'b1;
              end
            end
          endcase
        end
        S_CSLOW: begin                                // Then wait ready if busy-type
          mw_cs <= 1'b0;
          st_reg <= (mw_dat || cmd == CMD_ERASE || cmd == CMD_ERASE_ALL_CMD) ? S_BUSYW : S_DONE;
          q_reg <= 2'h0;
        end
        S_BUSYW: begin
          mw_cs <= tick ? 1'b1 : mw_cs;
          if (mw_cs && mdo_q) begin ready_busy_status <= 1'b1; st_reg <= S_DONE; end
        end
        default: begin
          eeprom_busy_bit <= 1'b0; mw_cs <= 1'b0; st_reg <= S_IDLE;
        end
      endcase
      // Whole-operation watchdog: slave stretch, polling or busy wait
      if (st_reg != S_IDLE && st_reg != S_DONE) begin
        tmo_reg <= tmo_reg + 22'h1;
        if (tmo_hit) begin eeprom_timeout_flag <= 1'b1; st_reg <= S_DONE; scl_oe <= 1'b0; sda_oe <= 1'b0; end
      end
    end
  end
endmodule : eeprom_master

// file: verification/eeprom_master_asserts.sv
// Port-level concurrent checks for the serial EEPROM master engine
`timescale 1ns/10ps
module eeprom_master_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       busy_set,
  input wire logic       eeprom_busy_bit,
  input wire logic       eeprom_timeout_flag,
  input wire logic [7:0] eeprom_data_register,
  input wire logic       seq_valid,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic       mw_cs,
  input wire logic       mw_sk,
  input wire logic       mw_di
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // =====================================
  // Helper: length of each low phase of the two-wire clock
  logic [15:0] low_reg;
  always_ff @(posedge clk) begin
    if (rst || !scl_oe) low_reg <= 16'h0000;
    else if (low_reg != 16'hffff) low_reg <= low_reg + 16'h0001;
  end
  // =====================================
  // Properties
  chk_cs_only_busy: assert property (!eeprom_busy_bit |-> !mw_cs)
    else $error("chip select high while idle");
  chk_sk_in_frame: assert property (mw_sk |-> mw_cs)
    else $error("serial clock outside a frame");
  chk_busy_starts: assert property (!eeprom_busy_bit && busy_set |=> eeprom_busy_bit)
    else $error("busy did not rise on request");
  chk_lines_idle: assert property (!eeprom_busy_bit |-> !scl_oe && !sda_oe)
    else $error("two-wire lines held while idle");
  chk_scl_low_time: assert property ($fell(scl_oe) |-> low_reg >= 16'h01d6)
    else $error("two-wire clock low phase too short");
  chk_flag_clears: assert property ($rose(eeprom_busy_bit) |-> ##[0:2] !eeprom_timeout_flag)
    else $error("timeout flag not cleared at start");
  chk_data_holds: assert property (!eeprom_busy_bit && !$past(eeprom_busy_bit) |-> $stable(eeprom_data_register))
    else $error("data changed while idle");
  chk_di_steady: assert property (mw_sk && $past(mw_sk) |-> $stable(mw_di))
    else $error("three-wire data moved with clock high");
  cover property ($fell(eeprom_busy_bit) && eeprom_timeout_flag);
  cover property ($rose(seq_valid));
  cover property ($fell(mw_cs));
endmodule : eeprom_master_asserts

bind eeprom_master eeprom_master_asserts chk (
  .clk(clk), .rst(rst), .busy_set(busy_set), .eeprom_busy_bit(eeprom_busy_bit),
  .eeprom_timeout_flag(eeprom_timeout_flag), .eeprom_data_register(eeprom_data_register),
  .seq_valid(seq_valid), .scl_oe(scl_oe), .sda_oe(sda_oe), .mw_cs(mw_cs), .mw_sk(mw_sk), .mw_di(mw_di)
);

// file: verification/eeprom_partner.sv
// Behavioural model of the external serial EEPROM, two-wire and three-wire
`timescale 1ns/10ps
module eeprom_partner (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,   // High pulls the data line low
  input  wire logic       nack,       // Withhold every ack
  input  wire logic [1:0] size_strap,
  input  wire logic       mw_cs,
  input  wire logic       mw_sk,
  input  wire logic       mw_di,
  output logic            mw_do
);
  // =====================================
  // Two-wire side
  logic [7:0] shift, rd_byte = 8'h5a;
  logic [3:0] bit_n = 4'h1;
  logic       reading = 1'b0, fresh = 1'b0;
  int         starts = 0, seen = 0;
  logic [7:0] q[$];
  initial sda_pull = 1'b0;
  // Start: data falls while the clock is high
  always @(negedge sda) if (scl) starts++;
  // Bits taken on the rising clock; the ninth is the ack slot
  always @(posedge scl) begin
    if (starts != seen) begin
      seen = starts;
      bit_n = 4'h0;
      reading = 1'b0;
      fresh = 1'b1;
    end
    if (bit_n == 4'h8) begin
      if (!reading) q.push_back(shift);
      if (reading) rd_byte = rd_byte + 8'h01;
      reading = (reading & !sda) | (fresh & shift[0]);
      fresh = 1'b0;
      bit_n = 4'h0;
    end else begin
      shift = {shift[6:0], sda};
      bit_n = bit_n + 4'h1;
    end
  end
  // Change the drive only on the falling clock; a master no-ack stops the stream
  always @(negedge scl) begin
    if (bit_n == 4'h8) sda_pull <= !reading && !nack;
    else sda_pull <= reading && !rd_byte[3'h7 - bit_n[2:0]];
  end
  // =====================================
  // Three-wire side
  logic [21:0] frame;
  logic [4:0]  sk_n;
  logic        dout = 1'b0;
  logic [7:0]  rd_word = 8'hc6;   // Fixed word returned by every read
  wire  [4:0]  hdr = 5'h0a + {2'h0, size_strap, 1'b0};
  always @(posedge mw_sk or posedge mw_cs) begin
    if (!mw_sk) begin
      sk_n <= 5'h00;
      frame <= 22'h000000;
    end else begin
      sk_n <= sk_n + 5'h01;
      frame <= {frame[20:0], mw_di};
      if (sk_n >= hdr && sk_n < hdr + 5'h08) dout <= rd_word[3'(5'h07 - (sk_n - hdr))];
    end
  end
  // Ready only before any clock; a released output toggles
  assign mw_do = (mw_cs && sk_n == 5'h00) ? 1'b1 : (mw_cs && sk_n > hdr) ? dout : !dout;
endmodule : eeprom_partner

// file: verification/serial_eeprom_master_engine_bench.sv
// Self-checking bench for the serial EEPROM master engine
`timescale 1ns/10ps
module serial_eeprom_master_engine_bench;
  import eeprom_master_pkg::*;
  logic        clk, rst, type_strap, busy_set, seq_next, nack;
  logic [1:0]  size_strap;
  logic [2:0]  cmd;
  logic [10:0] addr;
  logic [7:0]  wr_data, seq_count, data_reg;
  logic        busy, tmo, seq_valid, rdy, scl_oe, sda_oe, sda_pull, mw_cs, mw_sk, mw_di, mw_do;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || sda_pull);
  int          n_mismatch = 0, total_checks = 0, cycles = 0;
  logic [7:0]  got[$];
  eeprom_master dut (
    .clk(clk), .rst(rst), .type_strap(type_strap), .size_strap(size_strap), .busy_set(busy_set),
    .cmd(cmd), .eeprom_address_field(addr), .wr_data(wr_data), .seq_count(seq_count), .seq_next(seq_next),
    .eeprom_busy_bit(busy), .eeprom_timeout_flag(tmo), .eeprom_data_register(data_reg), .seq_valid(seq_valid),
    .ready_busy_status(rdy), .scl_in(scl), .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe),
    .mw_cs(mw_cs), .mw_sk(mw_sk), .mw_di(mw_di), .mw_do(mw_do)
  );
  eeprom_partner p (
    .scl(scl), .sda(sda), .sda_pull(sda_pull), .nack(nack), .size_strap(size_strap),
    .mw_cs(mw_cs), .mw_sk(mw_sk), .mw_di(mw_di), .mw_do(mw_do)
  );
  // =====================================
  // Clock, watchdog and loader-side byte taker
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 99000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  always @(negedge clk) begin
    if (seq_valid === 1'b1 && !seq_next) got.push_back(data_reg);
    seq_next <= seq_valid === 1'b1 && !seq_next;
  end
  // =====================================
  // Tasks
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : check
  // One operation; waits one cycle after idle before asking
  task automatic run(input logic ts, input logic [1:0] sz, input logic [2:0] c, input logic [10:0] a,
                     input logic [7:0] sc);
    @(negedge clk);
    type_strap = ts;
    size_strap = sz;
    cmd = c;
    addr = a;
    seq_count = sc;
    busy_set = 1'b1;
    @(negedge clk);
    busy_set = 1'b0;
    while (busy !== 1'b0) @(negedge clk);
  endtask : run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // =====================================
  // Main sequence
  initial begin
    {clk, rst, type_strap, busy_set, nack} = 5'h08;
    {size_strap, cmd, addr, wr_data, seq_count} = 32'h00000000;
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    nack = 1'b1;
    run(1'b0, 2'h0, CMD_READ, 11'h2c7, 8'h00);
    check(tmo, 32'h1, "abort flag");
    check(p.q.size(), 32'h1, "bytes before abort");
    $display("test abort done");
    nack = 1'b0;
    p.q.delete();
    run(1'b0, 2'h0, CMD_READ, 11'h2c7, 8'h01);
    check(tmo, 32'h0, "read flag");
    check({8'(p.q.size()), p.q[0], p.q[1], p.q[2]}, 32'h03a4c7a5, "control and address");
    check({16'(got.size()), got[0], got[1]}, 32'h00025a5b, "sequential bytes");
    check(data_reg, 32'h5b, "last byte in data");
    $display("test sequential read done");
    run(1'b1, 2'h0, CMD_READ, 11'h7b5, 8'h00);
    check(p.sk_n, 32'h12, "read clocks");
    check(p.frame[17:8], {3'h6, 7'h35}, "read header");
    check(data_reg, 32'hc6, "read data");
    check(tmo, 32'h0, "three-wire flag");
    $display("test three-wire read done");
    run(1'b1, 2'h1, CMD_WRITE_ENABLE_CMD, 11'h000, 8'h00);
    check(p.sk_n, 32'h0c, "enable clocks");
    check({mw_cs, p.frame[11:7]}, 32'h13, "enable header");
    $display("test enable done");
    wrap_up();
  end
endmodule : serial_eeprom_master_engine_bench
